// *** serial_irq_peripheral_tb_top.sv ***
// self-checking bench joining both ends of the serial interrupt link
`timescale 1ns/1ns
module serial_irq_peripheral_tb_top;
  localparam int LINES = 21;
  logic sys_clk;
  logic rst_n;
  logic start_req;
  logic quiet_next;
  logic dev_quiet;
  logic dev_active;
  logic host_quiet;
  logic cycle_done;
  logic first_done;
  logic [LINES-1:0] irq_lines;
  logic [LINES-1:0] reported;
  logic [LINES-1:0] irq_state;
  logic [LINES-1:0] pats [6];
  int fail_count;
  int check_count;
  // ----------------------------------------
  // clocks and instances
  // ----------------------------------------
  sirq_if i_sirq_if ();
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  initial begin
    i_sirq_if.pci_clk = 1'b0;
    #7;
    forever #80 i_sirq_if.pci_clk = ~i_sirq_if.pci_clk;
  end
  sirq_periph #(.LINES(LINES)) i_sirq_periph (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(i_sirq_if), .irq_lines(irq_lines), .quiet_mode(dev_quiet),
    .cycle_active(dev_active), .reported(reported));
  sirq_host #(.LINES(LINES)) i_sirq_host (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(i_sirq_if), .start_req(start_req), .quiet_next(quiet_next),
    .irq_state(irq_state), .cycle_done(cycle_done), .first_done(first_done),
    .quiet_mode(host_quiet));
  sirq_props #(.LINES(LINES)) i_sirq_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .pci_clk(i_sirq_if.pci_clk), .dev_o(i_sirq_if.dev_o), .dev_oe_n(i_sirq_if.dev_oe_n),
    .host_o(i_sirq_if.host_o), .host_oe_n(i_sirq_if.host_oe_n),
    .serial_interrupt_line(i_sirq_if.serial_interrupt_line));
  // ----------------------------------------
  // compare and sequence tasks
  // ----------------------------------------
  task automatic chk_vec(input string name, input logic [LINES-1:0] exp,
                         input logic [LINES-1:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (cycle_done !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("cycle_done", 1'b1, cycle_done);
  endtask
  task automatic run(input logic [LINES-1:0] p, input logic qn);
    @(negedge sys_clk);
    irq_lines = p;
    quiet_next = qn;
    start_req = 1'b1;
    wait_done();
    start_req = 1'b0;
    chk_vec("irq_state", p, irq_state);
    chk_vec("reported", p, reported);
    repeat (40) @(negedge sys_clk);
    chk_bit("dev quiet", qn, dev_quiet);
    chk_bit("host quiet", qn, host_quiet);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    results();
  end
  initial begin
    pats = '{21'h1FFFFF, 21'h155555, 21'h0AAAAA, 21'h000004, 21'h110001, 21'h000000};
    fail_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    start_req = 1'b0;
    quiet_next = 1'b0;
    irq_lines = pats[2];
    repeat (6) @(negedge sys_clk);
    chk_vec("irq_state", 21'h000000, irq_state);
    chk_bit("dev quiet", 1'b0, dev_quiet);
    rst_n = 1'b1;
    wait_done();
    chk_bit("first_done", 1'b1, first_done);
    chk_vec("irq_state", pats[2], irq_state);
    for (int i = 0; i < 6; i++) begin
      run(pats[i], 1'b0);
    end
    run(pats[0], 1'b1);
    repeat (200) @(negedge sys_clk);
    chk_bit("dev active", 1'b0, dev_active);
    irq_lines = pats[3];
    quiet_next = 1'b0;
    wait_done();
    chk_vec("irq_state", pats[3], irq_state);
    repeat (40) @(negedge sys_clk);
    chk_bit("dev quiet", 1'b0, dev_quiet);
    irq_lines = pats[4];
    repeat (300) @(negedge sys_clk);
    chk_bit("dev active", 1'b0, dev_active);
    start_req = 1'b1;
    repeat (600) @(negedge sys_clk);
    rst_n = 1'b0;
    start_req = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk_vec("reported", 21'h000000, reported);
    chk_bit("dev active", 1'b0, dev_active);
    chk_bit("first_done", 1'b0, first_done);
    chk_bit("line", 1'b1, i_sirq_if.serial_interrupt_line);
    rst_n = 1'b1;
    wait_done();
    chk_vec("irq_state", pats[4], irq_state);
    results();
  end
endmodule

// *** sirq_host.sv ***
// host controller end of the serial interrupt link
`timescale 1ns/1ns
`include "sirq_regs.svh"
module sirq_host
  import sirq_pkg::*;
#(
  parameter int LINES = `SIRQ_DATA_LINES,
  parameter int HOST_LOW = `SIRQ_HOST_LOW,
  parameter logic [LINES-1:0] DEFAULTS = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  sirq_if.host link,
  input wire logic start_req,
  input wire logic quiet_next,
  output logic [LINES-1:0] irq_state,
  output logic cycle_done,
  output logic first_done,
  output logic quiet_mode
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (LINES < 1 || LINES > `SIRQ_LINES_MAX) begin : g_bad_lines
      $error("sirq_host: LINES out of range");
    end
    if (HOST_LOW < `SIRQ_HOST_LOW_MIN || HOST_LOW > `SIRQ_HOST_LOW_MAX) begin : g_bad_low
      $error("sirq_host: HOST_LOW out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic pclk_s1_q;
  logic pclk_s2_q;
  logic pclk_s3_q;
  logic line_s1_q;
  logic line_s2_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // held high so release never shortens the first start clock
      pclk_s1_q <= 1'b1;
      pclk_s2_q <= 1'b1;
      pclk_s3_q <= 1'b1;
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      pclk_s1_q <= link.pci_clk;
      pclk_s2_q <= pclk_s1_q;
      pclk_s3_q <= pclk_s2_q;
      line_s1_q <= link.serial_interrupt_line;
      line_s2_q <= line_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  sirq_host_state_t state_q;
  sirq_host_state_t state_d;
  sirq_phase_t phase_q;
  sirq_phase_t phase_d;
  logic [5:0] frame_q;
  logic [5:0] frame_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic quiet_q;
  logic quiet_d;
  logic qnext_q;
  logic qnext_d;
  logic o_q;
  logic o_d;
  logic oe_n_q;
  logic oe_n_d;
  logic done_q;
  logic done_d;
  logic first_q;
  logic [LINES-1:0] irq_q;
  logic [LINES-1:0] irq_d;

  wire tick = pclk_s2_q && !pclk_s3_q;
  wire line_lo = !line_s2_q;
  wire [3:0] low_len = 4'(HOST_LOW);
  wire [3:0] stop_len = qnext_q ? `SIRQ_STOP_QUIET : `SIRQ_STOP_CONT;
  wire last_frame = frame_q == `SIRQ_FRAMES;
  wire cap_en = tick && (state_q == HS_DATA) && (phase_q == PH_SAMPLE);

  // level seen in each sample slot, low means active
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_cap
      assign irq_d[gi] = (cap_en && frame_q == 6'(gi + 1)) ? line_lo : irq_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // cycle state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    frame_d = frame_q;
    cnt_d = cnt_q;
    quiet_d = quiet_q;
    qnext_d = qnext_q;
    done_d = 1'b0;
    o_d = o_q;
    oe_n_d = oe_n_q;
    if (tick) begin
      o_d = 1'b1;
      oe_n_d = 1'b1;
      case (state_q)
        HS_IDLE: begin
          if (quiet_q && line_lo) begin
            state_d = HS_START;
            cnt_d = `SIRQ_QUIET_TAKEOVER;
            o_d = 1'b0;
            oe_n_d = 1'b0;
          end else if (!quiet_q && (start_req || !first_q)) begin
            state_d = HS_START;
            cnt_d = `SIRQ_CNT_ONE;
            o_d = 1'b0;
            oe_n_d = 1'b0;
          end
        end
        HS_START: begin
          if (cnt_q >= low_len) begin
            state_d = HS_HIGH;
            oe_n_d = 1'b0;
          end else begin
            cnt_d = cnt_q + `SIRQ_CNT_ONE;
            o_d = 1'b0;
            oe_n_d = 1'b0;
          end
        end
        HS_HIGH: begin
          state_d = HS_DATA;
          phase_d = PH_REC;
          frame_d = `SIRQ_FRM_ZERO;
        end
        HS_DATA: begin
          case (phase_q)
            PH_REC: phase_d = PH_TURN;
            PH_TURN: begin
              if (last_frame) begin
                state_d = HS_STOP;
                qnext_d = quiet_next;
                cnt_d = `SIRQ_CNT_ONE;
                o_d = 1'b0;
                oe_n_d = 1'b0;
              end else begin
                phase_d = PH_SAMPLE;
                frame_d = frame_q + `SIRQ_FRM_ONE;
              end
            end
            default: phase_d = PH_REC;
          endcase
        end
        default: begin
          if (cnt_q >= stop_len) begin
            state_d = HS_IDLE;
            quiet_d = qnext_q;
            done_d = 1'b1;
          end else begin
            cnt_d = cnt_q + `SIRQ_CNT_ONE;
            o_d = 1'b0;
            oe_n_d = 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HS_IDLE;
      phase_q <= PH_REC;
      frame_q <= `SIRQ_FRM_ZERO;
      cnt_q <= `SIRQ_CNT_ZERO;
      quiet_q <= 1'b0;
      qnext_q <= 1'b0;
      o_q <= 1'b1;
      oe_n_q <= 1'b1;
      done_q <= 1'b0;
      first_q <= 1'b0;
      irq_q <= DEFAULTS;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      frame_q <= frame_d;
      cnt_q <= cnt_d;
      quiet_q <= quiet_d;
      qnext_q <= qnext_d;
      o_q <= o_d;
      oe_n_q <= oe_n_d;
      done_q <= done_d;
      first_q <= first_q || done_d;
      irq_q <= irq_d;
    end
  end

  assign link.host_o = o_q;
  assign link.host_oe_n = oe_n_q;
  assign irq_state = irq_q;
  assign cycle_done = done_q;
  assign first_done = first_q;
  assign quiet_mode = quiet_q;

endmodule

// *** sirq_if.sv ***
// shared open-drain serial interrupt line with its pci clock
`timescale 1ns/1ns
interface sirq_if;
  logic pci_clk;
  logic dev_o;
  logic dev_oe_n;
  logic host_o;
  logic host_oe_n;
  wire serial_interrupt_line;
  // pulled up; any enabled low driver wins
  assign serial_interrupt_line = ((!dev_oe_n && !dev_o) || (!host_oe_n && !host_o)) ? 1'b0 : 1'b1;
  modport dev (
    input pci_clk,
    input serial_interrupt_line,
    output dev_o,
    output dev_oe_n
  );
  modport host (
    input pci_clk,
    input serial_interrupt_line,
    output host_o,
    output host_oe_n
  );
endinterface

// *** sirq_periph.sv ***
// peripheral end of the serial interrupt link
`timescale 1ns/1ns
`include "sirq_regs.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module sirq_periph
  import sirq_pkg::*;
#(
  parameter int LINES = `SIRQ_DATA_LINES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  sirq_if.dev link,
  input wire logic [LINES-1:0] irq_lines,
  output logic quiet_mode,
  output logic cycle_active,
  output logic [LINES-1:0] reported
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (LINES < 1 || LINES > `SIRQ_LINES_MAX) begin : g_bad_lines
      $error("sirq_periph: LINES out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // synchronisers for pci clock and line
  // ----------------------------------------------------------------
  logic pclk_s1_q;
  logic pclk_s2_q;
  logic pclk_s3_q;
  logic line_s1_q;
  logic line_s2_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // held high so release never shows a false rising edge
      pclk_s1_q <= 1'b1;
      pclk_s2_q <= 1'b1;
      pclk_s3_q <= 1'b1;
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      pclk_s1_q <= link.pci_clk;
      pclk_s2_q <= pclk_s1_q;
      pclk_s3_q <= pclk_s2_q;
      line_s1_q <= link.serial_interrupt_line;
      line_s2_q <= line_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sirq_dev_state_t state_q;
  sirq_dev_state_t state_d;
  sirq_phase_t phase_q;
  sirq_phase_t phase_d;
  logic [5:0] frame_q;
  logic [5:0] frame_d;
  logic [3:0] low_q;
  logic [3:0] low_d;
  logic quiet_q;
  logic quiet_d;
  logic o_q;
  logic o_d;
  logic oe_n_q;
  logic oe_n_d;
  logic active_q;
  logic [LINES-1:0] rep_q;
  logic [LINES-1:0] rep_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire tick = pclk_s2_q && !pclk_s3_q;
  wire line_lo = !line_s2_q;
  wire [5:0] frame_inc = frame_q + `SIRQ_FRM_ONE;
  wire [3:0] low_inc = (low_q == `SIRQ_CNT_MAX) ? low_q : low_q + `SIRQ_CNT_ONE;
  wire [63:0] irq_pad = 64'(irq_lines);
  wire own_frame = frame_q < 6'(LINES);
  wire sel_bit = own_frame && irq_pad[frame_q];
  wire pending = |(irq_lines ^ rep_q);
  wire last_frame = frame_q == `SIRQ_FRAMES;
  wire drove_low = !oe_n_q && !o_q;
  wire cap_en = tick && (state_q == DS_DATA) && (phase_q == PH_TURN) && !last_frame;

  // snapshot of the value reported in each sample slot
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_rep
      assign rep_d[gi] = (cap_en && frame_q == 6'(gi)) ? irq_lines[gi] : rep_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // frame state machine, advanced once per pci clock
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    frame_d = frame_q;
    low_d = low_q;
    quiet_d = quiet_q;
    o_d = 1'b1;
    oe_n_d = 1'b1;
    if (tick) begin
      case (state_q)
        DS_IDLE: begin
          if (line_lo) begin
            state_d = DS_START;
            low_d = `SIRQ_CNT_ONE;
          end else if (quiet_q && pending) begin
            o_d = 1'b0;
            oe_n_d = 1'b0;
          end
        end
        DS_START: begin
          if (line_lo) begin
            low_d = low_inc;
          end else begin
            // rising edge ends the start pulse
            state_d = DS_DATA;
            phase_d = PH_REC;
            frame_d = `SIRQ_FRM_ZERO;
          end
        end
        DS_DATA: begin
          case (phase_q)
            PH_REC: begin
              phase_d = PH_TURN;
            end
            PH_TURN: begin
              if (last_frame) begin
                state_d = DS_STOP;
                low_d = `SIRQ_CNT_ZERO;
              end else begin
                phase_d = PH_SAMPLE;
                frame_d = frame_inc;
                if (sel_bit) begin
                  o_d = 1'b0;
                  oe_n_d = 1'b0;
                end
              end
            end
            default: begin
              phase_d = PH_REC;
              if (drove_low) begin
                o_d = 1'b1;
                oe_n_d = 1'b0;
              end
            end
          endcase
        end
        default: begin
          // line is only watched here, never driven
          if (line_lo) begin
            low_d = low_inc;
          end else if (low_q != `SIRQ_CNT_ZERO) begin
            state_d = DS_IDLE;
            if (low_q == `SIRQ_STOP_QUIET) begin
              quiet_d = 1'b1;
            end else begin
              quiet_d = 1'b0;
            end
          end
        end
      endcase
    end else begin
      o_d = o_q;
      oe_n_d = oe_n_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DS_IDLE;
      phase_q <= PH_REC;
      frame_q <= `SIRQ_FRM_ZERO;
      low_q <= `SIRQ_CNT_ZERO;
      quiet_q <= 1'b0;
      o_q <= 1'b1;
      oe_n_q <= 1'b1;
      active_q <= 1'b0;
      rep_q <= '0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      frame_q <= frame_d;
      low_q <= low_d;
      quiet_q <= quiet_d;
      o_q <= o_d;
      oe_n_q <= oe_n_d;
      active_q <= state_d != DS_IDLE;
      rep_q <= rep_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.dev_o = o_q;
  assign link.dev_oe_n = oe_n_q;
  assign quiet_mode = quiet_q;
  assign cycle_active = active_q;
  assign reported = rep_q;

endmodule

// *** sirq_pkg.sv ***
// types shared by both ends of the serial interrupt link
package sirq_pkg;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_START = 2'b01,
    DS_DATA = 2'b10,
    DS_STOP = 2'b11
  } sirq_dev_state_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_START = 3'b001,
    HS_HIGH = 3'b010,
    HS_DATA = 3'b011,
    HS_STOP = 3'b100
  } sirq_host_state_t;
  typedef enum logic [1:0] {
    PH_SAMPLE = 2'b00,
    PH_REC = 2'b01,
    PH_TURN = 2'b10
  } sirq_phase_t;
endpackage

// *** sirq_props.sv ***
// concurrent checks on the shared serial interrupt line
`timescale 1ns/1ns
module sirq_props #(
  parameter int LINES = 21
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pci_clk,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic host_o,
  input wire logic host_oe_n,
  input wire logic serial_interrupt_line
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  wire dl = !dev_oe_n && !dev_o;
  wire dh = !dev_oe_n && dev_o;
  wire hl = !host_oe_n && !host_o;
  wire hh = !host_oe_n && host_o;
  logic hh_q;
  logic hl_q;
  logic in_cyc_q;
  logic seen_q;
  logic [11:0] fr_q;
  logic [7:0] lo_q;
  wire hh_rise = hh && !hh_q;
  wire hl_rise = hl && !hl_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hh_q <= 1'b0;
      hl_q <= 1'b0;
      in_cyc_q <= 1'b0;
      seen_q <= 1'b0;
      fr_q <= 12'h000;
      lo_q <= 8'h00;
    end else begin
      hh_q <= hh;
      hl_q <= hl;
      in_cyc_q <= hh_rise ? 1'b1 : (hl_rise ? 1'b0 : in_cyc_q);
      seen_q <= seen_q || hl;
      fr_q <= hh_rise ? 12'h001 : fr_q + {11'h000, fr_q != 12'hFFF};
      lo_q <= hl ? lo_q + 8'h01 : 8'h00;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  AST_DEV_LOW_ONE_CLK: assert property (
    $rose(dl) |-> dl[*8] ##1 dl[*8] ##1 !dl) else $error("device low drive not one clock");
  AST_DEV_HIGH_ONE_CLK: assert property (
    $rose(dh) |-> dh[*8] ##1 dh[*8] ##1 dev_oe_n) else $error("device recovery not one clock");
  AST_DEV_HIGH_AFTER_LOW: assert property (
    $rose(dh) |-> $past(dl)) else $error("device drove high without a low slot");
  AST_HOST_HIGH_ONE_CLK: assert property (
    $rose(hh) |-> hh[*8] ##1 hh[*8] ##1 host_oe_n) else $error("host high not one clock");
  AST_HOST_HIGH_AFTER_LOW: assert property (
    $rose(hh) |-> $past(hl)) else $error("host high not after start low");
  AST_HOST_LOW_WIDTH: assert property (
    hl_q && !hl |-> lo_q inside {[31:33], [47:49], [63:65]}) else $error("host low width bad");
  AST_FRAME_SLOT: assert property (
    $rose(dl) && in_cyc_q |-> (fr_q + 12'h001) % 12'h030 <= 12'h002 && fr_q <= LINES * 48 + 1)
    else $error("device sample outside its slot");
  AST_NO_DEV_FIRST: assert property (
    dl |-> seen_q) else $error("device started before host after reset");
  AST_DEV_QUIET_IN_HOST_LOW: assert property (
    hl && $past(hl) |-> dev_oe_n) else $error("device drove during host low");
  AST_DEV_DRIVE_ON_TICK: assert property (
    $changed(dev_o) || $changed(dev_oe_n) |-> $past(pci_clk, 3) && !$past(pci_clk, 4))
    else $error("device drive changed off a pci clock tick");
endmodule

// *** sirq_regs.svh ***
// timing and frame constants of the serial interrupt link
`ifndef SIRQ_REGS_SVH
`define SIRQ_REGS_SVH
`define SIRQ_FRAMES 6'h20
`define SIRQ_DATA_LINES 21
`define SIRQ_LINES_MAX 32
`define SIRQ_STOP_QUIET 4'h2
`define SIRQ_STOP_CONT 4'h3
`define SIRQ_HOST_LOW 4
`define SIRQ_HOST_LOW_MIN 4
`define SIRQ_HOST_LOW_MAX 8
`define SIRQ_QUIET_TAKEOVER 4'h2
`define SIRQ_CNT_ONE 4'h1
`define SIRQ_CNT_ZERO 4'h0
`define SIRQ_CNT_MAX 4'hF
`define SIRQ_FRM_ONE 6'h01
`define SIRQ_FRM_ZERO 6'h00
`endif
